/* hdl/ipsel_top.sv */
`timescale 1ns/1ps
`include "ipsel_cfg.svh"
module ipsel_top (
  input  wire logic                  sys_clk,    // 125 mhz system clock
  input  wire logic                  sys_rst,    // sync reset, active high
  input  wire ipsel_pkg::ipsel_req_t req,        // sfr bus request
  output logic [7:0]                 rdata,      // registered readback
  output ipsel_pkg::ipsel_prio_t     prio        // priority levels to arbiter
);
  import ipsel_pkg::*;

  // ****************************************
  // address decode
  // ****************************************
  // the full 8-bit address must match, so neighbouring sfrs never alias
  // onto this register; shared by the write path and the checks
  function automatic logic sfr_hit(input logic [7:0] addr);
    return addr == `IPSEL_REG_ADDR;
  endfunction : sfr_hit

  // ****************************************
  // register storage
  // ****************************************
  logic [7:0] interrupt_priority_levels; // held register value
  logic [7:0] next_levels;               // value after this edge
  logic       hit;                       // request aimed at register
  logic       byte_wr;                   // whole byte written
  logic       bit_wr;                    // single bit written

  // decode; a byte write wins when both strobes are up
  assign hit     = sfr_hit(req.addr);
  assign byte_wr = hit && req.wr_byte;
  assign bit_wr  = hit && !req.wr_byte && req.wr_bit;

  // byte write replaces low six bits, bit write touches one; top bits stay ones
  // the mask is forced after the merge so a bit write aimed at 7:6 is lost
  always_comb begin
    next_levels = interrupt_priority_levels;
    if (byte_wr) begin
      next_levels = req.wdata | `IPSEL_FIXED_MASK;
    end else if (bit_wr) begin
      next_levels[req.bit_sel] = req.wdata[0];
      next_levels = next_levels | `IPSEL_FIXED_MASK;
    end
  end

  // register update
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      interrupt_priority_levels <= `IPSEL_RESET_VALUE;
    end else begin
      interrupt_priority_levels <= next_levels;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  // outputs registered from next value so they track storage with no lag
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      rdata <= `IPSEL_RESET_VALUE;
      prio  <= '0;
    end else begin
      rdata                  <= next_levels;
      prio.timer2_priority   <= next_levels[`IPSEL_BIT_TIMER2];
      prio.serial0_priority  <= next_levels[`IPSEL_BIT_SERIAL0];
      prio.timer1_priority   <= next_levels[`IPSEL_BIT_TIMER1];
      prio.ext_irq1_priority <= next_levels[`IPSEL_BIT_EXT1];
      prio.timer0_priority   <= next_levels[`IPSEL_BIT_TIMER0];
      prio.ext_irq0_priority <= next_levels[`IPSEL_BIT_EXT0];
    end
  end

  // ****************************************
  // checks
  // ****************************************
  // all checks but the reset one are disabled while reset is applied

  // byte writes: every priority bit follows the written data one edge later
  // timer 2 source sits at bit 5
  chk_timer2_byte: assert property (@(posedge sys_clk) disable iff (sys_rst)
    hit && req.wr_byte |=> prio.timer2_priority == $past(req.wdata[5]))
    else $error("timer2 priority not taken");

  // uart0 source sits at bit 4
  chk_serial_byte: assert property (@(posedge sys_clk) disable iff (sys_rst)
    hit && req.wr_byte |=> prio.serial0_priority == $past(req.wdata[4]))
    else $error("uart0 priority not taken");

  // timer 1 source sits at bit 3
  chk_timer1_byte: assert property (@(posedge sys_clk) disable iff (sys_rst)
    hit && req.wr_byte |=> prio.timer1_priority == $past(req.wdata[3]))
    else $error("timer1 priority not taken");

  // external irq 1 sits at bit 2
  chk_ext1_byte: assert property (@(posedge sys_clk) disable iff (sys_rst)
    byte_wr |=> prio.ext_irq1_priority == $past(req.wdata[2]))
    else $error("ext1 priority not taken");

  // timer 0 source sits at bit 1
  chk_timer0_byte: assert property (@(posedge sys_clk) disable iff (sys_rst)
    byte_wr |=> prio.timer0_priority == $past(req.wdata[1]))
    else $error("timer0 priority not taken");

  // external irq 0 sits at bit 0
  chk_ext0_byte: assert property (@(posedge sys_clk) disable iff (sys_rst)
    byte_wr |=> prio.ext_irq0_priority == $past(req.wdata[0]))
    else $error("ext0 priority not taken");

  // both strobes up: the whole byte lands, the bit path is ignored
  // top bits still read ones whatever the data carried
  chk_byte_wins: assert property (@(posedge sys_clk) disable iff (sys_rst)
    hit && req.wr_byte && req.wr_bit
    |=> rdata == ($past(req.wdata) | `IPSEL_FIXED_MASK))
    else $error("byte write did not win over bit write");

  // bit writes: the selected bit takes wdata[0], the other five hold
  // one pair of checks per source so a swapped bit_sel decode shows up
  for (genvar gi = 0; gi < `IPSEL_NUM_SRC; gi++) begin : g_bit_chk
    // the addressed source takes the written value
    chk_bit_take: assert property (@(posedge sys_clk) disable iff (sys_rst)
      bit_wr && req.bit_sel == 3'(gi)
      |=> rdata[gi] == $past(req.wdata[0]))
      else $error("bit write not taken");

    // every other source keeps its level
    chk_bit_hold: assert property (@(posedge sys_clk) disable iff (sys_rst)
      bit_wr && req.bit_sel != 3'(gi)
      |=> rdata[gi] == $past(rdata[gi]))
      else $error("bit write disturbed a neighbour");
  end

  // timer 0 bit write seen on the priority output itself
  chk_timer0_bit: assert property (@(posedge sys_clk) disable iff (sys_rst)
    hit && !req.wr_byte && req.wr_bit && req.bit_sel == 3'h1
    |=> prio.timer0_priority == $past(req.wdata[0]))
    else $error("timer0 bit write lost");

  // a bit write aimed at the unused bits 7:6 changes nothing
  chk_fixed_bit: assert property (@(posedge sys_clk) disable iff (sys_rst)
    bit_wr && req.bit_sel[2:1] == 2'h3
    |=> rdata == $past(rdata))
    else $error("write to unused bit had an effect");

  // a bit write never moves more than one bit of the register
  chk_one_bit: assert property (@(posedge sys_clk) disable iff (sys_rst)
    bit_wr |=> $onehot0(rdata ^ $past(rdata)))
    else $error("bit write moved several bits");

  // unused bits read as ones at all times
  chk_top_ones: assert property (@(posedge sys_clk) disable iff (sys_rst)
    rdata[7:6] == 2'h3)
    else $error("unused bits not ones");

  // the arbiter sees the same external irq levels as a read of the register
  chk_ext_map: assert property (@(posedge sys_clk) disable iff (sys_rst)
    prio.ext_irq1_priority == rdata[2] && prio.ext_irq0_priority == rdata[0])
    else $error("external priority mismatch");

  // upper two sources mapped to bits 5 and 4
  chk_timer2_map: assert property (@(posedge sys_clk) disable iff (sys_rst)
    prio.timer2_priority == rdata[5] && prio.serial0_priority == rdata[4])
    else $error("priority output mismatch");

  // timer 1 and timer 0 sources mapped to bits 3 and 1
  chk_low_map: assert property (@(posedge sys_clk) disable iff (sys_rst)
    prio.timer1_priority == rdata[3] && prio.timer0_priority == rdata[1])
    else $error("timer priority output mismatch");

  // readback and storage are loaded together and must never drift apart
  chk_rdata_store: assert property (@(posedge sys_clk) disable iff (sys_rst)
    rdata == interrupt_priority_levels)
    else $error("readback differs from storage");

  // two idle cycles in a row leave the register alone
  chk_hold_idle: assert property (@(posedge sys_clk) disable iff (sys_rst)
    !hit ##1 !hit |=> $stable(rdata))
    else $error("register changed without access");

  // a request to any other address is ignored
  chk_miss_ignored: assert property (@(posedge sys_clk) disable iff (sys_rst)
    !hit |=> rdata == $past(rdata))
    else $error("foreign address changed register");

  // reset check runs without disable so that the reset edge itself is seen
  chk_reset_value: assert property (@(posedge sys_clk)
    sys_rst |=> rdata == `IPSEL_RESET_VALUE && prio == '0)
    else $error("reset value not loaded");
endmodule : ipsel_top

/* hdl/ipsel_cfg.svh */
`ifndef IPSEL_CFG_SVH
`define IPSEL_CFG_SVH
// ****************************************
// register map and field layout
// ****************************************
`define IPSEL_REG_ADDR     8'hB8
`define IPSEL_RESET_VALUE  8'hC0
`define IPSEL_FIXED_MASK   8'hC0
`define IPSEL_BIT_EXT0     0
`define IPSEL_BIT_TIMER0   1
`define IPSEL_BIT_EXT1     2
`define IPSEL_BIT_TIMER1   3
`define IPSEL_BIT_SERIAL0  4
`define IPSEL_BIT_TIMER2   5
`define IPSEL_NUM_SRC      6
`endif

/* hdl/ipsel_pkg.sv */
package ipsel_pkg;
  // one bit per source, 1 = high priority
  typedef struct packed {
    logic timer2_priority;
    logic serial0_priority;
    logic timer1_priority;
    logic ext_irq1_priority;
    logic timer0_priority;
    logic ext_irq0_priority;
  } ipsel_prio_t;

  // sfr bus request: byte write or single bit write
  typedef struct packed {
    logic [7:0] addr;
    logic       wr_byte;
    logic       wr_bit;
    logic [2:0] bit_sel;
    logic [7:0] wdata;
  } ipsel_req_t;
endpackage : ipsel_pkg

/* verif/ipsel_sfr_master.sv */
`timescale 1ns/1ps
// sfr bus master: one strobe per write, lines scrambled while idle
module ipsel_sfr_master (
  input  wire logic             sys_clk, // system clock
  output ipsel_pkg::ipsel_req_t req      // request to register
);
  import ipsel_pkg::*;
  initial req = '0;
  // drive after a falling edge, hold over one rising edge, then release
  task automatic put(input logic [7:0] a, input logic b, input logic [2:0] n,
                     input logic [7:0] d);
    @(negedge sys_clk);
    req = '{addr: a, wr_byte: b, wr_bit: !b, bit_sel: n, wdata: d};
    @(negedge sys_clk);
    req = '{addr: ~a, wr_byte: 1'b0, wr_bit: 1'b0, bit_sel: ~n, wdata: ~d};
  endtask : put
endmodule : ipsel_sfr_master

/* verif/interrupt_priority_select_tb_top.sv */
`timescale 1ns/1ps
module interrupt_priority_select_tb_top;
  import ipsel_pkg::*;
  logic        sys_clk = 1'b0;
  logic        sys_rst = 1'b1;
  ipsel_req_t  req;
  logic [7:0]  rdata;
  ipsel_prio_t prio;
  logic [7:0]  exp_v;
  int          n_errors = 0;
  int          n_checks = 0;
  always #4 sys_clk = ~sys_clk;
  ipsel_top i_ipsel_top (.sys_clk(sys_clk), .sys_rst(sys_rst), .req(req),
                         .rdata(rdata), .prio(prio));
  ipsel_sfr_master i_ipsel_sfr_master (.sys_clk(sys_clk), .req(req));
  // compare register and priority outputs against the expected byte
  task automatic chk(input logic [7:0] want);
    n_checks++;
    if (rdata !== want || {2'b11, prio} !== want) begin
      n_errors++;
      $display("Error t=%0t got=%h/%h exp=%h", $time, rdata, prio, want);
    end
  endtask : chk
  task automatic end_sim;
    $display("checks=%0d errors=%0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : end_sim
  // watchdog: the tests need about 50 cycles
  initial begin
    #3000;
    n_errors++;
    end_sim();
  end
  initial begin
    repeat (6) @(negedge sys_clk);
    sys_rst = 1'b0;
    chk(8'hC0);
    i_ipsel_sfr_master.put(8'hB8, 1'b1, 3'h0, 8'h21);
    chk(8'hE1);
    // a neighbouring address must not alias onto the register
    i_ipsel_sfr_master.put(8'hB9, 1'b1, 3'h0, 8'h1E);
    chk(8'hE1);
    i_ipsel_sfr_master.put(8'hB8, 1'b1, 3'h0, 8'h1E);
    chk(8'hDE);
    $display("byte writes done");
    // mid-run reset brings every source back to low priority
    i_ipsel_sfr_master.put(8'hB8, 1'b1, 3'h0, 8'h3F);
    chk(8'hFF);
    sys_rst = 1'b1;
    repeat (2) @(negedge sys_clk);
    sys_rst = 1'b0;
    chk(8'hC0);
    i_ipsel_sfr_master.put(8'hB8, 1'b1, 3'h0, 8'h1E);
    chk(8'hDE);
    $display("reset test done");
    exp_v = 8'hDE;
    // set then clear every bit singly, fixed bits 7:6 included
    for (int v = 1; v >= 0; v--) begin
      for (int i = 0; i < 8; i++) begin
        i_ipsel_sfr_master.put(8'hB8, 1'b0, 3'(i), 8'(v));
        if (i < 6) exp_v[i] = 1'(v);
        chk(exp_v);
      end
    end
    $display("bit writes done");
    end_sim();
  end
endmodule : interrupt_priority_select_tb_top
